// ### hdl/mode_timer_pkg.sv
// Constants and carrier types for the motor-unit mode timer
package mode_timer_pkg;

  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] IDX_CTRL_A      = 16'h1FA4;
  localparam logic [15:0] IDX_CTRL_B      = 16'h1FA5;
  localparam logic [15:0] IDX_CAPTURE     = 16'h1FA6;
  localparam logic [15:0] IDX_CMP_ONE     = 16'h1FA8;
  localparam logic [15:0] IDX_CMP_TWO     = 16'h1FAA;
  localparam logic [15:0] IDX_CMP_THREE   = 16'h1FAC;
  localparam logic [15:0] IDX_COUNT       = 16'h1F00;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'h1F01;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'h1F02;
  localparam logic [15:0] ADDR_CTRL_A     = 16'(IDX_CTRL_A * 4);
  localparam logic [15:0] ADDR_CTRL_B     = 16'(IDX_CTRL_B * 4);
  localparam logic [15:0] ADDR_CAPTURE    = 16'(IDX_CAPTURE * 4);
  localparam logic [15:0] ADDR_CMP_ONE    = 16'(IDX_CMP_ONE * 4);
  localparam logic [15:0] ADDR_CMP_TWO    = 16'(IDX_CMP_TWO * 4);
  localparam logic [15:0] ADDR_CMP_THREE  = 16'(IDX_CMP_THREE * 4);
  localparam logic [15:0] ADDR_COUNT      = 16'(IDX_COUNT * 4);
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'(IDX_IRQ_STATUS * 4);
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'(IDX_IRQ_MASK * 4);

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int A_ENABLE_BIT  = 0;
  localparam int A_PD_RST_BIT  = 1;
  localparam int A_SW_RST_BIT  = 2;
  localparam int A_PROT_RST_BIT = 3;
  localparam int A_T3_RST_BIT  = 4;
  localparam int B_PD_CAP_BIT  = 1;
  localparam int B_SW_CAP_BIT  = 2;
  localparam int B_PROT_CAP_BIT = 3;
  localparam int B_OVF_BIT     = 5;
  localparam int B_DEBUG_BIT   = 7;
  localparam int IRQ_OVF_BIT   = 0;
  localparam int IRQ_CAP_BIT   = 1;
  localparam int IRQ_W         = 2;

  // ----------------------------------------
  // Count clock selection codes and divider
  // ----------------------------------------
  localparam logic [2:0] SEL_DIV8   = 3'h0;
  localparam logic [2:0] SEL_DIV16  = 3'h2;
  localparam logic [2:0] SEL_DIV32  = 3'h4;
  localparam logic [2:0] SEL_DIV64  = 3'h6;
  localparam logic [2:0] SEL_DIV128 = 3'h1;
  localparam int         DIV_W      = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [1:0]  RST_IRQ     = 2'h0;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] clk_sel;
    logic       t3_rst_en;
    logic       prot_rst_en;
    logic       sw_rst;
    logic       pd_rst_en;
    logic       enable;
  } ctrl_a_t;

  typedef struct packed {
    logic debug_en;
    logic rsv6;
    logic ovf;
    logic rsv4;
    logic prot_cap_en;
    logic sw_cap;
    logic pd_cap_en;
    logic rsv0;
  } ctrl_b_t;

  typedef struct packed {
    logic pd_event;
    logic t3_event;
    logic prot_state;
  } motor_evt_t;

endpackage

// ### hdl/mode_timer_prescaler.sv
// Count clock divider for the mode timer
`timescale 1ns/100ps
module mode_timer_prescaler
  import mode_timer_pkg::*;
#(
  parameter int W = DIV_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  output logic            tick
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (W < 7) begin : g_bad_w
      $error("divider too narrow for the slowest rate");
    end
  endgenerate

  logic [W-1:0] div_cnt;
  logic [W-1:0] mask;
  logic         sel_ok;

  // Terminal mask per code, reserved codes never tick
  assign mask = (clk_sel == SEL_DIV8)   ? W'(7)   :
                (clk_sel == SEL_DIV16)  ? W'(15)  :
                (clk_sel == SEL_DIV32)  ? W'(31)  :
                (clk_sel == SEL_DIV64)  ? W'(63)  :
                (clk_sel == SEL_DIV128) ? W'(127) : '0;
  assign sel_ok = (clk_sel == SEL_DIV8) || (clk_sel == SEL_DIV16) ||
                  (clk_sel == SEL_DIV32) || (clk_sel == SEL_DIV64) ||
                  (clk_sel == SEL_DIV128);
  assign tick = run && sel_ok && ((div_cnt & mask) == mask);

  // Free divider, held clear while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (!run) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + W'(1);
    end
  end

endmodule

// ### hdl/motor_mode_timer_capture.sv
// Mode timer with capture, compare and APB register file
//
// Chosen here: register access over APB.
`timescale 1ns/100ps

// Functional notes
// - Enable bit 0 of control A runs the timer; cleared, it stays stopped.
// - Bits 7..5 of control A pick count clock: /8,/16,/32,/64,/128.
// - Bit 5 of control B reads 1 after an overflow, else 0.
// - Writing 1 to bit 2 of control B captures the count.
// - With bit 1 of control B set, position events capture the count.
// - With bit 3 of control B set, protection entry captures the count.
// - Writing 1 to bit 2 of control A clears the count.
// - With bit 1 of control A set, position events clear the count.
// - With bit 3 of control A set, protection entry clears the count.
// - With bit 4 of control A set, timer-3 events clear the count.
// - Bit 7 of control B drives the debug signal onto its pin.
module motor_mode_timer_capture
  import mode_timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire motor_evt_t        events,
  input  wire logic              debug_signal,
  output logic                   debug_pin,
  output logic [CNT_W-1:0]       count,
  output logic [15:0]            compare_one,
  output logic [15:0]            compare_two,
  output logic [15:0]            compare_three,
  output logic                   irq
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  generate
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt
      $error("count width must be 2 to 16");
    end
    if (IRQ_W != 2) begin : g_bad_irq
      $error("status layout holds exactly two event bits");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ctrl_a_t          ctrl_a;
  ctrl_b_t          ctrl_b;
  ctrl_b_t          ctrl_b_view;
  logic [15:0]      capture;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic             ovf_flag;
  logic             prot_q;
  logic [31:0]      next_prdata;
  logic [CNT_W-1:0] next_count;
  logic [15:0]      count_word;

  logic             setup_ph;
  logic             wr_acc;
  logic             rd_acc;
  logic             lo_wr;
  logic             hi_wr;
  logic             hit_a;
  logic             hit_b;
  logic             hit_cap;
  logic             hit_c1;
  logic             hit_c2;
  logic             hit_c3;
  logic             hit_cnt;
  logic             hit_ist;
  logic             hit_imsk;
  logic             mapped;

  logic             tick;
  logic             prot_entry;
  logic             sw_rst_req;
  logic             sw_cap_req;
  logic             pd_rst;
  logic             prot_rst;
  logic             t3_rst;
  logic             pd_cap;
  logic             prot_cap;
  logic             rst_req;
  logic             cap_req;
  logic             at_max;
  logic             ovf_evt;
  logic             ovf_clr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // ----------------------------------------
  // Bus phase and address decode
  // ----------------------------------------

  // Phases of an APB transfer
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign lo_wr    = wr_acc && pstrb[0];
  assign hi_wr    = wr_acc && pstrb[1];

  // Register hits
  assign hit_a    = (paddr == ADDR_CTRL_A);
  assign hit_b    = (paddr == ADDR_CTRL_B);
  assign hit_cap  = (paddr == ADDR_CAPTURE);
  assign hit_c1   = (paddr == ADDR_CMP_ONE);
  assign hit_c2   = (paddr == ADDR_CMP_TWO);
  assign hit_c3   = (paddr == ADDR_CMP_THREE);
  assign hit_cnt  = (paddr == ADDR_COUNT);
  assign hit_ist  = (paddr == ADDR_IRQ_STATUS);
  assign hit_imsk = (paddr == ADDR_IRQ_MASK);
  assign mapped   = hit_a || hit_b || hit_cap || hit_c1 || hit_c2 ||
                    hit_c3 || hit_cnt || hit_ist || hit_imsk;

  // No wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------
  // Read data
  // ----------------------------------------

  // Control B view: write-only strobe reads 0, flag shows overflow
  assign ctrl_b_view = '{debug_en:    ctrl_b.debug_en,
                         rsv6:        1'b0,
                         ovf:         ovf_flag,
                         rsv4:        1'b0,
                         prot_cap_en: ctrl_b.prot_cap_en,
                         sw_cap:      1'b0,
                         pd_cap_en:   ctrl_b.pd_cap_en,
                         rsv0:        1'b0};
  assign count_word  = 16'(count);

  // Read mux, sampled in the setup phase
  assign next_prdata = hit_a    ? {24'h000000, ctrl_a & 8'hFB} :
                       hit_b    ? {24'h000000, ctrl_b_view} :
                       hit_cap  ? {16'h0000, capture} :
                       hit_c1   ? {16'h0000, compare_one} :
                       hit_c2   ? {16'h0000, compare_two} :
                       hit_c3   ? {16'h0000, compare_three} :
                       hit_cnt  ? {16'h0000, count_word} :
                       hit_ist  ? {30'h00000000, irq_status} :
                       hit_imsk ? {30'h00000000, irq_mask} :
                       32'h00000000;

  // Read data register, loaded in the setup cycle
  // so it stands unchanged through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------

  // Control A, strobe bit never stored
  // so a read never shows a clear that already happened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a <= ctrl_a_t'(RST_CTRL);
    end else if (lo_wr && hit_a) begin
      ctrl_a        <= ctrl_a_t'(pwdata[7:0]);
      ctrl_a.sw_rst <= 1'b0;
    end
  end

  // Control B, strobe, flag and spare bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b <= ctrl_b_t'(RST_CTRL);
    end else if (lo_wr && hit_b) begin
      ctrl_b.debug_en    <= pwdata[B_DEBUG_BIT];
      ctrl_b.prot_cap_en <= pwdata[B_PROT_CAP_BIT];
      ctrl_b.pd_cap_en   <= pwdata[B_PD_CAP_BIT];
    end
  end

  // Compare registers, byte lanes honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_one   <= RST_WORD;
      compare_two   <= RST_WORD;
      compare_three <= RST_WORD;
    end else begin
      if (lo_wr && hit_c1) compare_one[7:0]    <= pwdata[7:0];
      if (hi_wr && hit_c1) compare_one[15:8]   <= pwdata[15:8];
      if (lo_wr && hit_c2) compare_two[7:0]    <= pwdata[7:0];
      if (hi_wr && hit_c2) compare_two[15:8]   <= pwdata[15:8];
      if (lo_wr && hit_c3) compare_three[7:0]  <= pwdata[7:0];
      if (hi_wr && hit_c3) compare_three[15:8] <= pwdata[15:8];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= RST_IRQ;
    end else if (lo_wr && hit_imsk) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Count clock
  // ----------------------------------------

  // Divider runs only while the timer is enabled
  // A rate change keeps the divider phase, so the first new tick may come early
  mode_timer_prescaler #(
    .W       (DIV_W)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctrl_a.enable),
    .clk_sel (ctrl_a.clk_sel),
    .tick    (tick)
  );

  // ----------------------------------------
  // Clear and capture sources
  // ----------------------------------------

  // Protection entry is the rising edge of its state
  // A level that stays high gives one entry only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= 1'b0;
    end else begin
      prot_q <= events.prot_state;
    end
  end
  assign prot_entry = events.prot_state && !prot_q;

  // Software strobes from writes of one
  assign sw_rst_req = lo_wr && hit_a && pwdata[A_SW_RST_BIT];
  assign sw_cap_req = lo_wr && hit_b && pwdata[B_SW_CAP_BIT];

  // Hardware sources gated by their enables
  assign pd_rst   = ctrl_a.pd_rst_en && events.pd_event;
  assign prot_rst = ctrl_a.prot_rst_en && prot_entry;
  assign t3_rst   = ctrl_a.t3_rst_en && events.t3_event;
  assign pd_cap   = ctrl_b.pd_cap_en && events.pd_event;
  assign prot_cap = ctrl_b.prot_cap_en && prot_entry;

  // Any enabled source clears or captures; sources may coincide
  assign rst_req = sw_rst_req || pd_rst || prot_rst || t3_rst;
  assign cap_req = sw_cap_req || pd_cap || prot_cap;

  // ----------------------------------------
  // Mode timer
  // ----------------------------------------

  // Next count: clear wins, else step on tick
  // A clear on the wrap edge suppresses the overflow event
  assign at_max     = (count == {CNT_W{1'b1}});
  assign ovf_evt    = tick && at_max && !rst_req;
  assign next_count = rst_req ? '0 :
                      tick    ? count + CNT_W'(1) :
                      count;

  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Capture takes the count before any same-cycle clear
  // because it samples the register, not next_count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= RST_WORD;
    end else if (cap_req) begin
      capture <= count_word;
    end
  end

  // ----------------------------------------
  // Overflow flag and interrupts
  // ----------------------------------------

  // Flag clears on a read of control B that showed it
  // An overflow landing in the same cycle wins over the clear
  assign ovf_clr = rd_acc && hit_b && prdata[B_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag <= 1'b1;
    end else if (ovf_clr) begin
      ovf_flag <= 1'b0;
    end
  end

  // Sticky events; a read clears only bits it returned
  assign irq_set = {cap_req, ovf_evt};
  assign irq_clr = (rd_acc && hit_ist) ? prdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // Level interrupt
  // Combinational, so it drops right after the clearing read
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // Debug output
  // ----------------------------------------

  // Registered pin drive, low while disabled
  // One cycle behind the debug signal, glitch free at the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_pin <= 1'b0;
    end else begin
      debug_pin <= ctrl_b.debug_en && debug_signal;
    end
  end

endmodule

// ### bench/mode_timer_props.sv
// Port-level assertions for the motor-unit mode timer
`timescale 1ns/100ps
module mode_timer_props
  import mode_timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire motor_evt_t        events,
  input wire logic              debug_signal,
  input wire logic              debug_pin,
  input wire logic [CNT_W-1:0]  count,
  input wire logic [15:0]       compare_one
);
  logic [7:0]       sa;
  logic [7:0]       sb;
  logic [CNT_W-1:0] cnt_q;
  logic             prot_q;
  logic             seen_wrap;
  // Decoded writes, clear requests and count steps
  wire wr   = psel && penable && pwrite && pstrb[0];
  wire wr_a = wr && paddr == ADDR_CTRL_A;
  wire rd_b = psel && penable && !pwrite && paddr == ADDR_CTRL_B;
  wire pr   = events.prot_state && !prot_q;
  wire clr  = (wr_a && pwdata[2]) || (events.pd_event && sa[1]) || (events.t3_event && sa[4]) || (pr && sa[3]);
  wire inc  = count == CNT_W'(cnt_q + 1'b1);
  // Shadow of control bits and past count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa        <= 8'h00;
      sb        <= 8'h00;
      cnt_q     <= '0;
      prot_q    <= 1'b0;
      seen_wrap <= 1'b0;
    end else begin
      sa        <= wr_a ? pwdata[7:0] : sa;
      sb        <= (wr && paddr == ADDR_CTRL_B) ? pwdata[7:0] : sb;
      cnt_q     <= count;
      prot_q    <= events.prot_state;
      seen_wrap <= seen_wrap || (count == '0 && cnt_q == '1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_count_stays_stopped: assert property (!sa[0] && !clr |=> $stable(count))
    else $error("count moved while stopped");
  a_tick_spacing: assert property (sa[0] && sa[7:5] == 3'h0 && inc |=> (!inc) [*7])
    else $error("ticks closer than eight cycles");
  a_ovf_flag_cause: assert property (rd_b && prdata[5] |-> seen_wrap)
    else $error("overflow flag without wrap");
  a_sw_clear: assert property (wr_a && pwdata[2] |=> count == '0)
    else $error("software clear missed");
  a_event_clear: assert property ((events.pd_event && sa[1]) || (events.t3_event && sa[4]) |=> count == '0)
    else $error("event clear missed");
  a_prot_clear: assert property (pr && sa[3] |=> count == '0)
    else $error("protection clear missed");
  a_debug_follows: assert property (1'b1 |=> debug_pin == $past(sb[7] && debug_signal))
    else $error("debug pin wrong");
  a_count_steps_one: assert property (sa[0] && !clr |=> count == $past(count) || count == CNT_W'($past(count) + 1))
    else $error("count jumped");
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("access not answered");
  a_compare_write: assert property (psel && penable && pwrite && pstrb[1:0] == 2'h3 && paddr == ADDR_CMP_ONE
    |=> compare_one == $past(pwdata[15:0]))
    else $error("compare write lost");
  c_wrap: cover property (inc && count == '0);
  c_pd_clear: cover property (events.pd_event && sa[1]);
  c_debug: cover property (debug_pin);
endmodule
bind motor_mode_timer_capture mode_timer_props #(.CNT_W(CNT_W)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .events(events), .debug_signal(debug_signal), .debug_pin(debug_pin),
  .count(count), .compare_one(compare_one));

// ### bench/tb_motor_mode_timer_capture.sv
// Self-checking bench for the motor-unit mode timer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_motor_mode_timer_capture;
  import mode_timer_pkg::*;
  localparam int CW = 8;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [15:0]   paddr = 16'h0000;
  logic [31:0]   pwdata = 32'h0;
  logic [3:0]    pstrb = 4'hF;
  motor_evt_t    events = 3'h0;
  logic          debug_signal = 1'b0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          debug_pin;
  logic          irq;
  logic [CW-1:0] count;
  logic [15:0]   cmp [3];
  int            n_mismatch = 0;
  int            comparisons = 0;
  int            cycles = 0;
  motor_mode_timer_capture #(.CNT_W(CW)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .debug_signal(debug_signal), .debug_pin(debug_pin), .count(count),
    .compare_one(cmp[0]), .compare_two(cmp[1]), .compare_three(cmp[2]), .irq(irq));
  // Clock and hang guard
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer plus an idle cycle; k is the count seen at the commit edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e, output logic [15:0] k);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    k = 16'(count);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    logic [15:0] k;
    apb(1'b1, a, d, r, e, k);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] r);
    logic        e;
    logic [15:0] k;
    apb(1'b0, a, 32'h0, r, e, k);
  endtask
  // Reset values, compare registers, read-only capture, unmapped place
  task automatic t_regs();
    logic [15:0] ad [6] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CAPTURE, ADDR_CMP_ONE, ADDR_CMP_TWO, ADDR_CMP_THREE};
    logic [31:0] r;
    logic        e;
    logic [15:0] k;
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], r);
      `CHK("reset_value", 32'h0, r)
    end
    for (int i = 0; i < 3; i++) begin
      wr(ad[3 + i], 32'h0000_A5C0 + i);
      rd(ad[3 + i], r);
      `CHK("compare_rd", 32'h0000_A5C0 + i, r)
      `CHK("compare_port", 16'hA5C0 + i, cmp[i])
    end
    pstrb <= 4'h2;
    wr(ADDR_CMP_ONE, 32'h0000_5A3C);
    pstrb <= 4'hF;
    `CHK("lane_write", 16'h5AC0, cmp[0])
    wr(ADDR_CAPTURE, 32'h0000_1234);
    rd(ADDR_CAPTURE, r);
    `CHK("capture_ro", 32'h0, r)
    apb(1'b0, 16'h0010, 32'h0, r, e, k);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
  endtask
  // Every clock code, a reserved code, then stop
  task automatic t_rates();
    logic [2:0]    code [5] = '{SEL_DIV8, SEL_DIV16, SEL_DIV32, SEL_DIV64, SEL_DIV128};
    logic [CW-1:0] c0;
    logic [31:0]   r;
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL_A, {24'h0, code[i], 5'h05});
      c0 = count;
      repeat ((8 << i) * 3) @(posedge pclk);
      `CHK("rate", CW'(c0 + 3), count)
    end
    wr(ADDR_CTRL_A, {24'h0, 3'h3, 5'h05});
    c0 = count;
    repeat (300) @(posedge pclk);
    `CHK("reserved_code", c0, count)
    wr(ADDR_CTRL_A, 32'h01);
    wr(ADDR_CTRL_A, 32'h00);
    c0 = count;
    repeat (100) @(posedge pclk);
    `CHK("stopped", c0, count)
    rd(ADDR_COUNT, r);
    `CHK("count_reg", {24'h0, c0}, r)
  endtask
  // Software capture, and a zero write that must not capture
  task automatic t_swcap();
    logic [31:0] r;
    logic        e;
    logic [15:0] k;
    wr(ADDR_CTRL_A, 32'h05);
    repeat (30) @(posedge pclk);
    apb(1'b1, ADDR_CTRL_B, 32'h04, r, e, k);
    rd(ADDR_CAPTURE, r);
    `CHK("sw_capture", {16'h0, k}, r)
    repeat (30) @(posedge pclk);
    wr(ADDR_CTRL_B, 32'h00);
    rd(ADDR_CAPTURE, r);
    `CHK("sw_capture_zero", {16'h0, k}, r)
    rd(ADDR_CTRL_A, r);
    `CHK("clear_bit_reads_0", 32'h01, r)
  endtask
  // One event of kind k with the given enables; judge clear and capture
  task automatic t_evt(input int k, input logic [7:0] a, input logic [7:0] b, input logic rst, input logic cap);
    logic [31:0]   r;
    logic [31:0]   cap0;
    logic [CW-1:0] c;
    wr(ADDR_CTRL_A, {24'h0, a | 8'h04});
    wr(ADDR_CTRL_B, {24'h0, b});
    rd(ADDR_CAPTURE, cap0);
    repeat (40) @(posedge pclk);
    case (k)
      0: events.pd_event <= 1'b1;
      1: events.t3_event <= 1'b1;
      default: events.prot_state <= 1'b1;
    endcase
    @(posedge pclk);
    c = count;
    events <= 3'h0;
    @(posedge pclk);
    `CHK("event_clear", rst, count === '0)
    rd(ADDR_CAPTURE, r);
    `CHK("event_capture", cap ? {24'h0, c} : cap0, r)
  endtask
  // Overflow flag, read clear, interrupt mask
  task automatic t_ovf();
    logic [31:0] r;
    wr(ADDR_IRQ_MASK, 32'h01);
    wr(ADDR_CTRL_A, 32'h05);
    rd(ADDR_CTRL_B, r);
    `CHK("no_overflow", 1'b0, r[5])
    repeat (2100) @(posedge pclk);
    `CHK("irq_set", 1'b1, irq)
    rd(ADDR_CTRL_B, r);
    `CHK("overflow", 1'b1, r[5])
    rd(ADDR_CTRL_B, r);
    `CHK("overflow_cleared", 1'b0, r[5])
    wr(ADDR_IRQ_MASK, 32'h00);
    `CHK("irq_masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h01);
    `CHK("irq_unmasked", 1'b1, irq)
    rd(ADDR_IRQ_STATUS, r);
    `CHK("status_ovf", 1'b1, r[0])
    `CHK("status_cap", 1'b1, r[1])
    `CHK("irq_cleared", 1'b0, irq)
  endtask
  // Debug pin gating
  task automatic t_debug();
    debug_signal <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("debug_off", 1'b0, debug_pin)
    wr(ADDR_CTRL_B, 32'h80);
    @(posedge pclk);
    `CHK("debug_on", 1'b1, debug_pin)
    debug_signal <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("debug_low", 1'b0, debug_pin)
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_rates();
    t_swcap();
    t_evt(0, 8'h03, 8'h02, 1'b1, 1'b1);
    t_evt(0, 8'h01, 8'h00, 1'b0, 1'b0);
    t_evt(1, 8'h11, 8'h00, 1'b1, 1'b0);
    t_evt(1, 8'h01, 8'h00, 1'b0, 1'b0);
    t_evt(2, 8'h09, 8'h08, 1'b1, 1'b1);
    t_evt(2, 8'h01, 8'h08, 1'b0, 1'b1);
    t_evt(2, 8'h01, 8'h00, 1'b0, 1'b0);
    t_ovf();
    t_debug();
    end_of_test();
  end
endmodule
